// file: common/adc_cfg_params.svh
`ifndef ADC_CFG_PARAMS_SVH
`define ADC_CFG_PARAMS_SVH
// register addresses
`define ADDR_CONV_SETUP      4'h1
`define ADDR_INTEG_CURRENT   4'h2
`define ADDR_ROUTE_READOUT   4'h3
// reset values
`define RESET_REG            8'h00
// write masks: writable bits of each register
`define WMASK_CONV_SETUP     8'hFF
`define WMASK_INTEG_CURRENT  8'h7F
`define WMASK_ROUTE_READOUT  8'hFD
// current code limit and reserved codes
`define RATE_CODE_RESERVED   3'h7
`define ROUTE_CODE_RESERVED  3'h7
`define CHECK_CODE_RESERVED  2'h3
`define CURRENT_CODE_MAX     3'h6
// conversion setup field positions
`define RATE_HI              7
`define RATE_LO              5
`define TURBO_BIT            4
`define CONV_MODE_BIT        3
`define REF_HI               2
`define REF_LO               1
`define TEMP_BIT             0
// integrity and current setup field positions
`define COUNTER_BIT          6
`define CHECK_HI             5
`define CHECK_LO             4
`define BURNOUT_BIT          3
`define CURRENT_HI           2
`define CURRENT_LO           0
// routing and readout field positions
`define ROUTE_ONE_HI         7
`define ROUTE_ONE_LO         5
`define ROUTE_TWO_HI         4
`define ROUTE_TWO_LO         2
`define RESERVED_BIT         1
`define AUTO_READ_BIT        0
`endif

// file: common/adc_cfg_pkg.sv
package adc_cfg_pkg;
   // reference source choice
   typedef enum logic [1:0]
   {
      REF_INTERNAL,
      REF_EXTERNAL,
      REF_SUPPLY
   } refSel_t;

   // integrity check choice
   typedef enum logic [1:0]
   {
      CHECK_NONE,
      CHECK_INVERTED,
      CHECK_CRC16,
      CHECK_RESERVED
   } checkSel_t;

   // register access request
   typedef struct packed
   {
      logic       wrEn;
      logic       rdEn;
      logic [3:0] addr;
      logic [7:0] wrData;
   } regReq_t;

   // decoded configuration going to the converter
   typedef struct packed
   {
      logic [2:0] convRateSel;
      logic       turboMode;
      logic       convModeSel;
      refSel_t    refSel;
      logic       tempSenseEn;
      logic       ignoreInputCfg;
      logic       dataCounterEn;
      checkSel_t  checkSel;
      logic       burnoutSourceEn;
      logic [2:0] excitationCurrentSel;
      logic [2:0] sourceOneRoute;
      logic [2:0] sourceTwoRoute;
      logic       autoReadMode;
   } cfgOut_t;

   // all state of the bank
   typedef struct packed
   {
      logic [7:0] convSetup;
      logic [6:0] integCurrent;
      logic [7:0] routeReadout;
      logic       resultReadyFlag;
      logic [7:0] rdData;
      logic       rdValid;
      cfgOut_t    cfg;
   } bankState_t;
endpackage : adc_cfg_pkg

// file: hw/adc_config_register_bank.sv
`include "adc_cfg_params.svh"

// Behaviour
// - conversion setup bits 7:5 hold the rate code, meaning set by mode
// - rate codes 0..6 give 20..1000 SPS normal, doubled turbo; 7 reserved
// - bit 4 picks normal 256 kHz or turbo 512 kHz modulator clock
// - bit 3 picks single-shot or continuous conversion
// - bits 2:1 pick internal, external, or analog supply reference
// - temperature mode ignores input config and uses internal reference
// - ready flag sets on new result, clears when result data read
// - register two bit 6 enables the conversion data counter
// - bits 5:4 pick no check, inverted copy, or CRC16; 11 reserved
// - register two bit 3 switches the burn-out current sources
// - bits 2:0 set one shared excitation current magnitude
// - registers at addresses 1, 2, 3, each resetting to zero
// - register three routes source one (7:5) and two (4:2)
// - register three bit 0 picks manual or automatic result readout
module adc_config_register_bank
   import adc_cfg_pkg::*;
(
   input  wire logic    clk,
   input  wire logic    rstn,
   input  wire regReq_t req,
   input  wire logic    resultNew,
   input  wire logic    resultRead,
   output logic [7:0]   rdData,
   output logic         rdValid,
   output cfgOut_t      cfg
);

   bankState_t state_ff;
   bankState_t nxt_state;

   // ***************************************************************
   // helpers
   // ***************************************************************

   // merge write data under a writable-bit mask
   function automatic logic [7:0] maskedWrite(input logic [7:0] old,
                                              input logic [7:0] data,
                                              input logic [7:0] mask);
      maskedWrite = (old & ~mask) | (data & mask);
   endfunction : maskedWrite

   // reference code to enum, both supply codes folded
   function automatic refSel_t decodeRef(input logic [1:0] code);
      decodeRef = code[1] ? REF_SUPPLY : refSel_t'(code);
   endfunction : decodeRef

   // ***************************************************************
   // register writes
   // ***************************************************************

   // register writes under the writable-bit masks; unmapped addresses ignored
   function automatic bankState_t applyWrite(input bankState_t st,
                                             input regReq_t    rq);
      bankState_t s;
      s = st;
      if (rq.wrEn)
      begin
         unique case (rq.addr)
            // rate, mode, reference and temperature bits
            `ADDR_CONV_SETUP:
               s.convSetup = maskedWrite(st.convSetup, rq.wrData,
                                         `WMASK_CONV_SETUP);
            // ready flag is kept apart, so a write cannot reach it
            `ADDR_INTEG_CURRENT:
               s.integCurrent = rq.wrData[6:0];
            // reserved bit masked off
            `ADDR_ROUTE_READOUT:
               s.routeReadout = maskedWrite(st.routeReadout, rq.wrData,
                                            `WMASK_ROUTE_READOUT);
            default:
               s = st;
         endcase
      end
      applyWrite = s;
   endfunction : applyWrite

   // ***************************************************************
   // ready flag
   // ***************************************************************

   // a new result wins over a read of the result in the same cycle
   function automatic logic nextReadyFlag(input logic flag,
                                          input logic setEv,
                                          input logic clearEv);
      logic f;
      f = flag;
      // clear first, so a set in the same cycle overrides it
      if (clearEv)
         f = 1'b0;
      if (setEv)
         f = 1'b1;
      nextReadyFlag = f;
   endfunction : nextReadyFlag

   // ***************************************************************
   // readback
   // ***************************************************************

   // byte seen by a read at one address; unmapped addresses read zero
   function automatic logic [7:0] readImage(input logic [3:0] addr,
                                            input bankState_t st);
      logic [7:0] image;
      image = `RESET_REG;
      unique case (addr)
         // whole register
         `ADDR_CONV_SETUP:
            image = st.convSetup;
         // ready flag on top of the writable fields
         `ADDR_INTEG_CURRENT:
            image = {st.resultReadyFlag, st.integCurrent};
         // reserved bit always reads zero
         `ADDR_ROUTE_READOUT:
         begin
            image                = st.routeReadout;
            image[`RESERVED_BIT] = 1'b0;
         end
         default:
            image = `RESET_REG;
      endcase
      readImage = image;
   endfunction : readImage

   // ***************************************************************
   // configuration decode
   // ***************************************************************

   // rate, mode and reference; temperature mode forces the internal reference
   function automatic cfgOut_t decodeSetup(input cfgOut_t    base,
                                           input logic [7:0] setup);
      cfgOut_t c;
      c                = base;
      c.convRateSel    = setup[`RATE_HI:`RATE_LO];
      c.turboMode      = setup[`TURBO_BIT];
      c.convModeSel    = setup[`CONV_MODE_BIT];
      c.tempSenseEn    = setup[`TEMP_BIT];
      c.ignoreInputCfg = setup[`TEMP_BIT];
      // both supply codes fold to one choice
      if (setup[`TEMP_BIT])
         c.refSel      = REF_INTERNAL;
      else
         c.refSel      = decodeRef(setup[`REF_HI:`REF_LO]);
      decodeSetup = c;
   endfunction : decodeSetup

   // counter enable, integrity check, burn-out and excitation current
   function automatic cfgOut_t decodeInteg(input cfgOut_t    base,
                                           input logic [6:0] integ);
      cfgOut_t c;
      c                      = base;
      // reserved check code passed through unchanged
      c.dataCounterEn        = integ[`COUNTER_BIT];
      c.checkSel             = checkSel_t'(integ[`CHECK_HI:`CHECK_LO]);
      c.burnoutSourceEn      = integ[`BURNOUT_BIT];
      c.excitationCurrentSel = integ[`CURRENT_HI:`CURRENT_LO];
      decodeInteg = c;
   endfunction : decodeInteg

   // excitation routing and result readout mode; reserved bit not decoded
   function automatic cfgOut_t decodeRoute(input cfgOut_t    base,
                                           input logic [7:0] route);
      cfgOut_t c;
      c                = base;
      c.sourceOneRoute = route[`ROUTE_ONE_HI:`ROUTE_ONE_LO];
      c.sourceTwoRoute = route[`ROUTE_TWO_HI:`ROUTE_TWO_LO];
      c.autoReadMode   = route[`AUTO_READ_BIT];
      decodeRoute = c;
   endfunction : decodeRoute

   // ***************************************************************
   // next state
   // ***************************************************************

   // register writes, ready flag, readback, decoded outputs
   always_comb
   begin
      // writes first; the read answer pulse drops unless a read is taken
      nxt_state         = applyWrite(state_ff, req);
      nxt_state.rdValid = 1'b0;
      // ready flag from this cycle's result events
      nxt_state.resultReadyFlag = nextReadyFlag(state_ff.resultReadyFlag,
                                                resultNew,
                                                resultRead);
      // readback from the old values, so a same-cycle write reads the old byte
      if (req.rdEn)
      begin
         nxt_state.rdValid = 1'b1;
         nxt_state.rdData  = readImage(req.addr, state_ff);
      end
      // decoded configuration follows the new register values
      nxt_state.cfg = '0;
      nxt_state.cfg = decodeSetup(nxt_state.cfg, nxt_state.convSetup);
      nxt_state.cfg = decodeInteg(nxt_state.cfg, nxt_state.integCurrent);
      nxt_state.cfg = decodeRoute(nxt_state.cfg, nxt_state.routeReadout);
   end

   // ***************************************************************
   // state register
   // ***************************************************************

   // all fields reset to zero
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         state_ff <= '0;
      else
         state_ff <= nxt_state;
   end

   // ***************************************************************
   // outputs
   // ***************************************************************

   // outputs straight from flip-flops
   assign rdData  = state_ff.rdData;
   assign rdValid = state_ff.rdValid;
   assign cfg     = state_ff.cfg;

endmodule : adc_config_register_bank

// file: test/adc_cfg_checker_assertions.sv
module adc_cfg_checker
   import adc_cfg_pkg::*;
(
   input wire logic       clk,
   input wire logic       rstn,
   input wire regReq_t    req,
   input wire logic       resultNew,
   input wire logic       resultRead,
   input wire logic [7:0] rdData,
   input wire logic       rdValid,
   input wire cfgOut_t    cfg
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // write strobes per register
   wire logic w1 = req.wrEn && req.addr == 4'h1;
   wire logic w2 = req.wrEn && req.addr == 4'h2;
   wire logic w3 = req.wrEn && req.addr == 4'h3;
   AST_RD_PULSE: assert property (1'b1 |=> rdValid == $past(req.rdEn))
      else $error("read answer not one cycle after strobe");
   AST_RATE_MODE: assert property (w1 |=> {cfg.convRateSel, cfg.turboMode,
      cfg.convModeSel} == $past(req.wrData[7:3])) else $error("rate or mode wrong");
   AST_REF_SEL: assert property (w1 && !req.wrData[0] |=> cfg.refSel ==
      ($past(req.wrData[2]) ? REF_SUPPLY : refSel_t'($past(req.wrData[2:1]))))
      else $error("reference choice wrong");
   AST_TEMP_MODE: assert property (w1 && req.wrData[0] |=> cfg.tempSenseEn
      && cfg.ignoreInputCfg && cfg.refSel == REF_INTERNAL) else $error("temp mode wrong");
   AST_REG_TWO: assert property (w2 |=> {cfg.dataCounterEn, cfg.checkSel,
      cfg.burnoutSourceEn, cfg.excitationCurrentSel} == $past(req.wrData[6:0]))
      else $error("register two fields wrong");
   AST_REG_THREE: assert property (w3 |=> {cfg.sourceOneRoute, cfg.sourceTwoRoute,
      cfg.autoReadMode} == {$past(req.wrData[7:2]), $past(req.wrData[0])})
      else $error("register three fields wrong");
   AST_READY_SET: assert property (resultNew ##1 req.rdEn && req.addr == 4'h2
      |=> rdData[7]) else $error("ready flag not set");
   AST_READY_CLEAR: assert property (resultRead && !resultNew ##1 req.rdEn
      && req.addr == 4'h2 |=> !rdData[7]) else $error("ready flag not cleared");
   AST_RSVD_ZERO: assert property (req.rdEn && req.addr == 4'h3 |=> !rdData[1])
      else $error("reserved bit not zero");
   AST_UNMAPPED: assert property (req.rdEn && (req.addr == 4'h0 || req.addr > 4'h3)
      |=> rdData == 8'h00) else $error("unmapped read not zero");
   cover property (w1 ##2 req.rdEn);
   cover property (resultNew && resultRead);
   cover property (cfg.tempSenseEn);
endmodule : adc_cfg_checker

bind adc_config_register_bank adc_cfg_checker adc_cfg_checker_i(.clk, .rstn, .req,
   .resultNew, .resultRead, .rdData, .rdValid, .cfg);

// file: test/host_model.sv
module host_model
   import adc_cfg_pkg::*;
(
   input  wire logic [7:0] rdData,
   input  wire logic       rdValid,
   input  wire logic       clk,
   output regReq_t         req
);
   timeunit 1ns;
   timeprecision 1ps;
   initial req = '0;
   // one-cycle write strobe from a falling edge, then one idle cycle
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      req = '{1'b1, 1'b0, a, d};
      @(negedge clk);
      req = '{1'b0, 1'b0, 4'hF, ~d};
      @(negedge clk);
   endtask : wr
   // one-cycle read strobe; answer taken just after it is lifted, then one idle cycle
   task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic v);
      req = '{1'b0, 1'b1, a, 8'hA5};
      @(negedge clk);
      req = '{1'b0, 1'b0, 4'hF, 8'h5A};
      d = rdData;
      v = rdValid;
      @(negedge clk);
   endtask : rd
endmodule : host_model

// file: test/tb_top.sv
module tb_top
   import adc_cfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [3:0] a; logic [7:0] d; logic [7:0] e;} row_t;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic resultNew = 1'b0;
   logic resultRead = 1'b0;
   logic [7:0] rdData;
   logic       rdValid;
   regReq_t    req;
   cfgOut_t    cfg;
   int         miscompares = 0;
   int         nChecks     = 0;
   int         cycles      = 0;
   // address, write data, expected readback; no reserved codes, reserved bit zero
   row_t       rows [4] = '{'{4'h1, 8'hDF, 8'hDF}, '{4'h2, 8'hEE, 8'h6E},
      '{4'h3, 8'hD9, 8'hD9}, '{4'h5, 8'hFF, 8'h00}};
   // decoded configuration after the rows
   cfgOut_t    expCfg = '{3'h6, 1'b1, 1'b1, REF_INTERNAL, 1'b1, 1'b1, 1'b1, CHECK_CRC16,
      1'b1, 3'h6, 3'h6, 3'h6, 1'b1};
   always #12.5 clk = ~clk;
   adc_config_register_bank adc_config_register_bank_i(.clk, .rstn, .req, .resultNew,
      .resultRead, .rdData, .rdValid, .cfg);
   host_model host_model_i(.rdData, .rdValid, .clk, .req);
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      nChecks++;
      if (g !== e)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // decoded configuration compare
   task automatic chkCfg(input string nm, input cfgOut_t e);
      nChecks++;
      if (cfg !== e)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, cfg);
      end
   endtask : chkCfg
   // read one register: data, answer pulse, and the pulse dropping after
   task automatic rdChk(input string nm, input logic [3:0] a, input logic [7:0] e);
      logic [7:0] g;
      logic       v;
      host_model_i.rd(a, g, v);
      chk(nm, e, g);
      chk("read valid", 8'h01, {7'h00, v});
      chk("read valid drop", 8'h00, {7'h00, rdValid});
   endtask : rdChk
   // one-cycle result events
   task automatic ev(input logic n, input logic r);
      {resultNew, resultRead} = {n, r};
      @(negedge clk);
      {resultNew, resultRead} = 2'b00;
   endtask : ev
   task automatic stop_test();
      $display("checks %0d mismatches %0d", nChecks, miscompares);
      if (miscompares == 0 && nChecks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : stop_test
   // hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         miscompares++;
         stop_test();
      end
   end
   // main sequence
   initial
   begin
      repeat (4) @(negedge clk);
      rstn = 1'b1;
      for (int i = 1; i < 4; i++)
         rdChk("reset value", 4'(i), 8'h00);
      foreach (rows[i])
      begin
         host_model_i.wr(rows[i].a, rows[i].d);
         rdChk("readback", rows[i].a, rows[i].e);
      end
      chkCfg("cfg decode", expCfg);
      chk("refSel temp", 8'h00, 8'(cfg.refSel));
      host_model_i.wr(4'h1, 8'h02);
      chk("refSel external", 8'h01, 8'(cfg.refSel));
      host_model_i.wr(4'h1, 8'h06);
      chk("refSel supply", 8'h02, 8'(cfg.refSel));
      ev(1'b1, 1'b0);
      host_model_i.wr(4'h2, 8'h00);
      rdChk("flag kept", 4'h2, 8'h80);
      ev(1'b0, 1'b1);
      rdChk("flag cleared", 4'h2, 8'h00);
      ev(1'b1, 1'b1);
      rdChk("flag set", 4'h2, 8'h80);
      // mid-run reset clears registers, flag and outputs
      rstn = 1'b0;
      repeat (4) @(negedge clk);
      chkCfg("cfg in reset", '0);
      chk("rdData in reset", 8'h00, rdData);
      rstn = 1'b1;
      for (int i = 1; i < 4; i++)
         rdChk("reset again", 4'(i), 8'h00);
      stop_test();
   end
endmodule : tb_top
